// >>> include/cgs_pkg.sv
package cgs_pkg;

  // ----------------------------------------------------------------
  // Bus addressing and command code
  // ----------------------------------------------------------------
  localparam logic [6:0] CGS_DEV_ADDR = 7'h69;
  localparam int CGS_CMD_SINGLE_BIT = 7;
  localparam int CGS_NUM_CFG = 4;
  localparam int CGS_CFG_IDX_W = 2;

  // ----------------------------------------------------------------
  // Configuration bytes: index, reset value, writable bits
  // ----------------------------------------------------------------
  localparam int CGS_IDX_SPREAD_FREQ = 0;
  localparam int CGS_IDX_HOST_66M = 1;
  localparam int CGS_IDX_PERIPH = 2;
  localparam int CGS_IDX_FREE_DBG_REF = 3;
  localparam logic [7:0] CGS_CFG_RST [CGS_NUM_CFG] =
    '{8'h00, 8'hFF, 8'h7F, 8'hEB};
  localparam logic [7:0] CGS_CFG_WMASK [CGS_NUM_CFG] =
    '{8'hFF, 8'hFF, 8'h7F, 8'hEB};

  // Field positions
  localparam int CGS_SPREAD_MSB = 7;
  localparam int CGS_SPREAD_LSB = 5;
  localparam int CGS_SOFT_FREQ_CODE_B4 = 4;
  localparam int CGS_SOFT_FREQ_CODE_B0 = 0;
  localparam int CGS_HOST_CLK_PAIR_ONE_EN = 7;
  localparam int CGS_HOST_CLK_PAIR_ZERO_EN = 6;
  localparam int CGS_USB_RATE_OUT_EN = 5;
  localparam int CGS_DUAL_RATE_OUT_EN = 4;
  localparam int CGS_MID_RATE_OUT_THREE_EN = 3;
  localparam int CGS_MID_RATE_OUT_ZERO_EN = 0;
  localparam int CGS_PERIPH_CLK_SIX_EN = 6;
  localparam int CGS_PERIPH_CLK_ZERO_EN = 0;
  localparam int CGS_FREE_PERIPH_CLK_TWO_EN = 7;
  localparam int CGS_FREE_PERIPH_CLK_ZERO_EN = 5;
  localparam int CGS_DEBUG_PORT_CLK_EN = 3;
  localparam int CGS_REF_OUT_ONE_EN = 1;
  localparam int CGS_REF_OUT_ZERO_EN = 0;
  localparam int CGS_NUM_GATED = 21;

  // ----------------------------------------------------------------
  // Controller timing and software registers
  // ----------------------------------------------------------------
  localparam int CGS_CLK_PERIOD_NS = 20;
  localparam int CGS_SCL_PERIOD_NS = 10000;
  localparam int CGS_QTR_CYCLES = CGS_SCL_PERIOD_NS / (4 * CGS_CLK_PERIOD_NS);
  localparam logic [2:0] CGS_H_INDEX = 3'h0;
  localparam logic [2:0] CGS_H_WDATA = 3'h1;
  localparam logic [2:0] CGS_H_CTRL = 3'h2;
  localparam logic [2:0] CGS_H_STATUS = 3'h3;
  localparam logic [2:0] CGS_H_RDATA = 3'h4;
  localparam int CGS_CTRL_GO_WR = 0;
  localparam int CGS_CTRL_GO_RD = 1;

  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_CMD, D_WDATA, D_ACK, D_RDATA, D_RACK, D_IGNORE
  } cgs_dev_state_t;

  typedef enum logic [2:0] {
    IT_START, IT_TX, IT_RX, IT_STOP, IT_DONE
  } cgs_item_t;

endpackage

// >>> include/cgs_smb_if.sv
`timescale 1ns/100ps
interface cgs_smb_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // --------------------------------------------------------------
  // Open-drain wire resolution with pull-ups
  // --------------------------------------------------------------
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
    input scl, sda
  );
  modport dev (
    output dev_sda_o, dev_sda_oe,
    input scl, sda
  );
endinterface

// >>> rtl/cgs_out_gate.sv
`timescale 1ns/100ps
module cgs_out_gate #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] src_in,
  input wire logic [WIDTH-1:0] en_in,
  output logic [WIDTH-1:0] clk_out
);
  logic [WIDTH-1:0] run;

  // --------------------------------------------------------------
  // Gate state changes only while the source is low
  // --------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      run <= '0;
      clk_out <= '0;
    end else begin
      run <= (run & src_in) | (en_in & ~src_in);
      clk_out <= src_in & run;
    end
  end
endmodule

// >>> rtl/cgs_dev_end.sv
`timescale 1ns/100ps
// Summary of operation
// - Command top bit set: single byte, low index
// - Start, address, direction; address acknowledged first
// - Byte write: address, command, data, all acknowledged
// - Byte read: repeated start, one byte, host nacks
// - Byte 0 bits 7:5 spread mode, reset zero
// - Byte 0 bits 4:0 frequency code, reset zero
// - Byte 1 bits 7:4 host/usb/dual enables, one
// - Byte 1 bits 3:0 mid-rate enables, reset one
// - Byte 3 free/debug/ref enables; bits 4,2 zero
// - Answer only address D2 write, D3 read
module cgs_dev_end
  import cgs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  cgs_smb_if.dev smb,
  input wire logic [CGS_NUM_GATED-1:0] out_src_in,
  output logic [CGS_NUM_GATED-1:0] out_clk_out,
  output logic [2:0] spread_sel_out,
  output logic [4:0] soft_freq_code_out,
  output logic [7:0] host_66m_en_out,
  output logic [7:0] periph_en_out,
  output logic [7:0] free_dbg_ref_en_out
);
  logic scl_q;
  logic sda_q;
  cgs_dev_state_t state;
  cgs_dev_state_t after_ack;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [6:0] index;
  logic sda_drive;
  logic [7:0] cfg [CGS_NUM_CFG];

  // --------------------------------------------------------------
  // Line event decode
  // --------------------------------------------------------------
  wire scl_rise = smb.scl & ~scl_q;
  wire scl_fall = ~smb.scl & scl_q;
  wire start_seen = smb.scl & scl_q & sda_q & ~smb.sda;
  wire stop_seen = smb.scl & scl_q & ~sda_q & smb.sda;
  wire byte_done = scl_fall & (bit_cnt == 4'h8);
  wire addr_hit = (shreg[7:1] == CGS_DEV_ADDR);
  wire cmd_single = shreg[CGS_CMD_SINGLE_BIT];
  wire idx_ok = (index < 7'(CGS_NUM_CFG));
  wire [CGS_CFG_IDX_W-1:0] idx_sel = index[CGS_CFG_IDX_W-1:0];
  wire [7:0] rd_byte = idx_ok ? cfg[idx_sel] : 8'h00;
  wire wr_strobe = (state == D_WDATA) & byte_done & idx_ok;

  // --------------------------------------------------------------
  // Acknowledge decision and follow-on state per received byte
  // --------------------------------------------------------------
  wire rx_ack = (state == D_ADDR) ? addr_hit :
                (state == D_CMD) ? cmd_single :
                1'b1;
  cgs_dev_state_t rx_next;
  assign rx_next = (state == D_ADDR) ?
                   (shreg[0] ? D_RDATA : D_CMD) :
                   (state == D_CMD) ? D_WDATA : D_IGNORE;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= smb.scl;
      sda_q <= smb.sda;
    end
  end

  // --------------------------------------------------------------
  // Serial slave state machine
  // --------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= D_IDLE;
      after_ack <= D_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      index <= 7'h00;
      sda_drive <= 1'b0;
    end else if (stop_seen) begin
      state <= D_IDLE;
      sda_drive <= 1'b0;
    end else if (start_seen) begin
      state <= D_ADDR;
      bit_cnt <= 4'h0;
      sda_drive <= 1'b0;
    end else begin
      case (state)
        D_ADDR, D_CMD, D_WDATA: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], smb.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            bit_cnt <= 4'h0;
            if (state == D_CMD) begin
              index <= shreg[6:0];
            end
            if (rx_ack) begin
              sda_drive <= 1'b1;
              after_ack <= rx_next;
              state <= D_ACK;
            end else begin
              state <= D_IGNORE;
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            state <= after_ack;
            shreg <= rd_byte;
            sda_drive <= (after_ack == D_RDATA) & ~rd_byte[7];
          end
        end
        D_RDATA: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_drive <= 1'b0;
              bit_cnt <= 4'h0;
              state <= D_RACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_drive <= ~shreg[6];
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            state <= D_IGNORE;
          end
        end
        D_IDLE, D_IGNORE: begin
          state <= state;
        end
        default: begin
          state <= D_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Configuration bytes
  // --------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < CGS_NUM_CFG; i++) begin
        cfg[i] <= CGS_CFG_RST[i];
      end
    end else if (wr_strobe) begin
      cfg[idx_sel] <= shreg & CGS_CFG_WMASK[idx_sel];
    end
  end

  // --------------------------------------------------------------
  // Open-drain data pin
  // --------------------------------------------------------------
  assign smb.dev_sda_o = 1'b0;
  assign smb.dev_sda_oe = sda_drive;

  // --------------------------------------------------------------
  // Register field outputs
  // --------------------------------------------------------------
  assign spread_sel_out =
    cfg[CGS_IDX_SPREAD_FREQ][CGS_SPREAD_MSB:CGS_SPREAD_LSB];
  assign soft_freq_code_out = cfg[CGS_IDX_SPREAD_FREQ]
    [CGS_SOFT_FREQ_CODE_B4:CGS_SOFT_FREQ_CODE_B0];
  assign host_66m_en_out = cfg[CGS_IDX_HOST_66M];
  assign periph_en_out = cfg[CGS_IDX_PERIPH];
  assign free_dbg_ref_en_out = cfg[CGS_IDX_FREE_DBG_REF];

  // --------------------------------------------------------------
  // Output gating
  // --------------------------------------------------------------
  wire [7:0] fdr = cfg[CGS_IDX_FREE_DBG_REF];
  wire [7:0] hm = cfg[CGS_IDX_HOST_66M];
  wire [2:0] free_periph_en =
    fdr[CGS_FREE_PERIPH_CLK_TWO_EN:CGS_FREE_PERIPH_CLK_ZERO_EN];
  wire debug_port_en = fdr[CGS_DEBUG_PORT_CLK_EN];
  wire [1:0] ref_en = fdr[CGS_REF_OUT_ONE_EN:CGS_REF_OUT_ZERO_EN];
  wire [6:0] periph_clk_en =
    cfg[CGS_IDX_PERIPH][CGS_PERIPH_CLK_SIX_EN:CGS_PERIPH_CLK_ZERO_EN];
  wire [3:0] host_usb_dual_en =
    hm[CGS_HOST_CLK_PAIR_ONE_EN:CGS_DUAL_RATE_OUT_EN];
  wire [3:0] mid_rate_en =
    hm[CGS_MID_RATE_OUT_THREE_EN:CGS_MID_RATE_OUT_ZERO_EN];
  wire [CGS_NUM_GATED-1:0] gate_en = {
    free_periph_en, debug_port_en, ref_en,
    periph_clk_en, host_usb_dual_en, mid_rate_en
  };

  cgs_out_gate #(
    .WIDTH(CGS_NUM_GATED)
  ) u_gate (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .src_in(out_src_in),
    .en_in(gate_en),
    .clk_out(out_clk_out)
  );
endmodule

// >>> rtl/cgs_host_end.sv
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
module cgs_host_end
  import cgs_pkg::*;
#(
  parameter int QTR_CYCLES = CGS_QTR_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  cgs_smb_if.host smb,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);
  logic [6:0] index;
  logic [7:0] wdata;
  logic [7:0] rx;
  logic nack_err;
  logic busy;
  logic is_read;
  logic [2:0] seq;
  logic [1:0] q;
  logic [3:0] bit_cnt;
  logic [15:0] qcnt;
  logic scl_lvl;
  logic sda_lvl;

  function automatic cgs_item_t item_of(input logic [2:0] s,
                                        input logic rd);
    cgs_item_t it;
    it = IT_DONE;
    case (s)
      3'h0: it = IT_START;
      3'h1, 3'h2: it = IT_TX;
      3'h3: it = rd ? IT_START : IT_TX;
      3'h4: it = rd ? IT_TX : IT_STOP;
      3'h5: it = rd ? IT_RX : IT_DONE;
      3'h6: it = rd ? IT_STOP : IT_DONE;
      default: it = IT_DONE;
    endcase
    return it;
  endfunction

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  cgs_item_t item;
  assign item = item_of(seq, is_read);
  wire ctrl_wr = reg_wr_in & (reg_addr_in == CGS_H_CTRL) & ~busy;
  wire go_rd = ctrl_wr & reg_wdata_in[CGS_CTRL_GO_RD];
  wire go_wr = ctrl_wr & reg_wdata_in[CGS_CTRL_GO_WR] & ~go_rd;
  wire tick = busy & (qcnt == 16'(QTR_CYCLES - 1));
  wire [7:0] tx_byte = (seq == 3'h1) ? {CGS_DEV_ADDR, 1'b0} :
                       (seq == 3'h2) ? {1'b1, index} :
                       (seq == 3'h4) ? {CGS_DEV_ADDR, 1'b1} :
                       wdata;
  wire [7:0] tx_sh = tx_byte << bit_cnt;
  wire ack_slot = (bit_cnt == 4'h8);
  wire bit_val = (item == IT_TX) & ~ack_slot ? tx_sh[7] : 1'b1;
  wire [2:0] stop_seq = is_read ? 3'h6 : 3'h4;
  wire [2:0] next_seq = (item == IT_TX) & nack_err ? stop_seq : seq + 3'h1;

  // --------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      index <= 7'h00;
      wdata <= 8'h00;
    end else if (reg_wr_in & ~busy) begin
      if (reg_addr_in == CGS_H_INDEX) begin
        index <= reg_wdata_in[6:0];
      end
      if (reg_addr_in == CGS_H_WDATA) begin
        wdata <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        CGS_H_INDEX: reg_rdata_out <= {1'b0, index};
        CGS_H_WDATA: reg_rdata_out <= wdata;
        CGS_H_STATUS: reg_rdata_out <= {6'h00, nack_err, busy};
        CGS_H_RDATA: reg_rdata_out <= rx;
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // --------------------------------------------------------------
  // Quarter-bit divider
  // --------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      qcnt <= 16'h0000;
    end else if (~busy | tick) begin
      qcnt <= 16'h0000;
    end else begin
      qcnt <= qcnt + 16'h0001;
    end
  end

  // --------------------------------------------------------------
  // Bus sequencer
  // --------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy <= 1'b0;
      is_read <= 1'b0;
      nack_err <= 1'b0;
      seq <= 3'h0;
      q <= 2'h0;
      bit_cnt <= 4'h0;
      scl_lvl <= 1'b1;
      sda_lvl <= 1'b1;
      rx <= 8'h00;
    end else if (~busy) begin
      if (go_wr | go_rd) begin
        busy <= 1'b1;
        is_read <= go_rd;
        nack_err <= 1'b0;
        seq <= 3'h0;
        q <= 2'h0;
        bit_cnt <= 4'h0;
      end
    end else if (tick) begin
      q <= q + 2'h1;
      case (item)
        IT_START: begin
          case (q)
            2'h0: sda_lvl <= 1'b1;
            2'h1: scl_lvl <= 1'b1;
            2'h2: sda_lvl <= 1'b0;
            default: begin
              scl_lvl <= 1'b0;
              seq <= seq + 3'h1;
            end
          endcase
        end
        IT_TX, IT_RX: begin
          case (q)
            2'h0: sda_lvl <= bit_val;
            2'h1: scl_lvl <= 1'b1;
            2'h2: begin
              if (~ack_slot & (item == IT_RX)) begin
                rx <= {rx[6:0], smb.sda};
              end
              if (ack_slot & (item == IT_TX) & smb.sda) begin
                nack_err <= 1'b1;
              end
            end
            default: begin
              scl_lvl <= 1'b0;
              if (ack_slot) begin
                bit_cnt <= 4'h0;
                seq <= next_seq;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          endcase
        end
        IT_STOP: begin
          case (q)
            2'h0: sda_lvl <= 1'b0;
            2'h1: scl_lvl <= 1'b1;
            2'h2: sda_lvl <= 1'b1;
            default: busy <= 1'b0;
          endcase
        end
        default: begin
          busy <= 1'b0;
        end
      endcase
    end
  end

  assign smb.host_scl_o = 1'b0;
  assign smb.host_scl_oe = ~scl_lvl;
  assign smb.host_sda_o = 1'b0;
  assign smb.host_sda_oe = ~sda_lvl;
endmodule

// >>> dv/cgs_chk.sv
`timescale 1ns/100ps
module cgs_chk
  import cgs_pkg::*;
#(
  parameter int QTR_CYCLES = CGS_QTR_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // ----------------------------------------------------------------
  // Wire framing tracker
  // ----------------------------------------------------------------
  logic scl_q;
  logic sda_q;
  logic [9:0] lo_cnt;
  logic [3:0] bitc;
  logic [1:0] byten;
  logic [7:0] sh;
  logic first;
  logic addr_wr;
  wire start_seen = scl && scl_q && sda_q && !sda;
  wire rise = scl && !scl_q;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      lo_cnt <= '0;
      bitc <= '0;
      byten <= '0;
      sh <= '0;
      first <= 1'b0;
      addr_wr <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      lo_cnt <= scl ? '0 : lo_cnt + 10'd1;
      if (start_seen) begin
        bitc <= '0;
        byten <= '0;
        first <= 1'b1;
      end else if (rise) begin
        sh <= {sh[6:0], sda};
        bitc <= (bitc == 4'd8) ? 4'd0 : bitc + 4'd1;
        if (bitc == 4'd8) begin
          byten <= byten + 2'd1;
          first <= 1'b0;
        end
        if (bitc == 4'd8 && first) begin
          addr_wr <= (sh == {CGS_DEV_ADDR, 1'b0});
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rst;
    $fell(reset_in) |-> !dev_sda_oe && !host_sda_oe && !host_scl_oe;
  endproperty
  property p_od;
    !host_scl_o && !host_sda_o && !dev_sda_o;
  endproperty
  property p_hold;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  property p_scl_low;
    rise |-> lo_cnt >= 2*QTR_CYCLES-1 && lo_cnt <= 2*QTR_CYCLES+1;
  endproperty
  property p_start;
    scl && $past(scl) && $fell(sda) |-> host_sda_oe && !dev_sda_oe;
  endproperty
  property p_one_drv;
    scl && dev_sda_oe |-> !host_sda_oe;
  endproperty
  property p_ack_addr;
    rise && bitc == 4'd8 && first |->
      dev_sda_oe == (sh[7:1] == CGS_DEV_ADDR);
  endproperty
  property p_cmd_ack;
    rise && bitc == 4'd8 && byten == 2'd1 && addr_wr |-> dev_sda_oe == sh[7];
  endproperty

  a_rst: assert property (p_rst)
    else $error("bus not released after reset");
  a_od: assert property (p_od)
    else $error("open drain line driven high");
  a_hold: assert property (p_hold)
    else $error("device moved sda while scl high");
  a_scl_low: assert property (p_scl_low)
    else $error("scl low time off");
  a_start: assert property (p_start)
    else $error("start not made by host");
  a_one_drv: assert property (p_one_drv)
    else $error("both ends drive sda");
  a_ack_addr: assert property (p_ack_addr)
    else $error("address acknowledge wrong");
  a_cmd_ack: assert property (p_cmd_ack)
    else $error("command acknowledge wrong");

  c_start: cover property (start_seen);
  c_ack: cover property (rise && bitc == 4'd8 && first && dev_sda_oe);
  c_stop: cover property (scl && scl_q && !sda_q && sda);
endmodule

// >>> dv/test_clock_gen_smbus_config_bytes.sv
`timescale 1ns/100ps
module test_clock_gen_smbus_config_bytes
  import cgs_pkg::*;
;
  localparam int QTR = 2;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [CGS_NUM_GATED-1:0] src = '0;
  logic [CGS_NUM_GATED-1:0] src_q = '0;
  logic [CGS_NUM_GATED-1:0] gated;
  logic [2:0] spread;
  logic [4:0] freq;
  logic [7:0] en1;
  logic [7:0] en2;
  logic [7:0] en3;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  int cfg_m [4] = '{8'h00, 8'hff, 8'h7f, 8'heb};
  int wmask [4] = '{8'hff, 8'hff, 8'h7f, 8'heb};

  cgs_smb_if smb ();
  cgs_host_end #(.QTR_CYCLES(QTR)) u_cgs_host_end (.clk_in(clk_in),
    .reset_in(reset_in), .smb(smb), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata));
  cgs_dev_end u_cgs_dev_end (.clk_in(clk_in), .reset_in(reset_in),
    .smb(smb), .out_src_in(src), .out_clk_out(gated),
    .spread_sel_out(spread), .soft_freq_code_out(freq),
    .host_66m_en_out(en1), .periph_en_out(en2), .free_dbg_ref_en_out(en3));
  cgs_chk #(.QTR_CYCLES(QTR)) u_cgs_chk (.clk_in(clk_in),
    .reset_in(reset_in), .host_scl_o(smb.host_scl_o),
    .host_scl_oe(smb.host_scl_oe), .host_sda_o(smb.host_sda_o),
    .host_sda_oe(smb.host_sda_oe), .dev_sda_o(smb.dev_sda_o),
    .dev_sda_oe(smb.dev_sda_oe), .scl(smb.scl), .sda(smb.sda));

  always #10 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    src_q <= src;
    src <= cycles[1] ? '1 : '0;
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk_in);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Idle cycle keeps strobes of two calls apart
    @(posedge clk_in);
  endtask

  // Read data stands in the cycle after the strobe, taken at its end
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    bus(1'b0, a, 8'h00);
    d = reg_rdata;
  endtask

  task automatic run(input int idx, input logic go_rd, input logic [7:0] d);
    int k;
    logic [7:0] st;
    bus(1'b1, CGS_H_INDEX, 8'(idx));
    bus(1'b1, CGS_H_WDATA, d);
    bus(1'b1, CGS_H_CTRL, go_rd ? 8'h02 : 8'h01);
    k = 0;
    do begin
      rd(CGS_H_STATUS, st);
      k++;
    end while (st[0] !== 1'b0 && k < 2000);
    check("status", st, 8'h00);
  endtask

  task automatic wr_cfg(input int idx, input logic [7:0] d);
    run(idx, 1'b0, d);
    if (idx < 4) cfg_m[idx] = d & wmask[idx];
  endtask

  task automatic chk_cfg(input int idx);
    logic [7:0] d;
    run(idx, 1'b1, 8'h00);
    rd(CGS_H_RDATA, d);
    check("cfg byte", d, idx < 4 ? cfg_m[idx] : 0);
  endtask

  task automatic chk_ports();
    check("spread", spread, cfg_m[0][7:5]);
    check("freq code", freq, cfg_m[0][4:0]);
    check("byte1 enables", en1, cfg_m[1]);
    check("byte2 enables", en2, cfg_m[2]);
    check("byte3 enables", en3, cfg_m[3]);
    repeat (8) @(posedge clk_in);
    repeat (8) begin
      @(negedge clk_in);
      check("gated", gated, src_q & {cfg_m[3][7:5], cfg_m[3][3],
        cfg_m[3][1:0], cfg_m[2][6:0], cfg_m[1][7:0]});
    end
    @(posedge clk_in);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hc1fa_9445));
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 6; i++) chk_cfg(i == 5 ? 127 : i);
    chk_ports();
    $display("test reset values done");
    for (int i = 0; i < 6; i++) wr_cfg(i == 5 ? 127 : i, 8'($urandom));
    for (int i = 0; i < 6; i++) chk_cfg(i == 5 ? 127 : i);
    chk_ports();
    $display("test random writes done");
    for (int i = 1; i < 4; i++) wr_cfg(i, 8'h00);
    chk_ports();
    for (int i = 1; i < 4; i++) wr_cfg(i, 8'hff);
    for (int i = 1; i < 4; i++) chk_cfg(i);
    chk_ports();
    $display("test output gating done");
    for (int m = 0; m < 8; m++) begin
      wr_cfg(0, {m[2:0], 5'($urandom)});
      check("spread mode", spread, m[2:0]);
      check("freq code", freq, cfg_m[0][4:0]);
    end
    chk_cfg(0);
    $display("test spread modes done");
    report_and_stop();
  end
endmodule
